// File: hdl/spimsp_regs.svh
`ifndef SPIMSP_REGS_SVH
`define SPIMSP_REGS_SVH

// Mode field codes
`define SPIMSP_MODE_DIV4 4'h0
`define SPIMSP_MODE_DIV16 4'h1
`define SPIMSP_MODE_DIV64 4'h2
`define SPIMSP_MODE_TMR2 4'h3
`define SPIMSP_MODE_SLV_SS 4'h4
`define SPIMSP_MODE_SLV_FREE 4'h5

// Serial clock rate: system clock divided by 4, 16 or 64
`define SPIMSP_RATE_DIV4 4
`define SPIMSP_RATE_DIV16 16
`define SPIMSP_RATE_DIV64 64
// Half periods in system clocks, minus one, for the prescaler
`define SPIMSP_HALF_DIV4 6'((`SPIMSP_RATE_DIV4 / 2) - 1)
`define SPIMSP_HALF_DIV16 6'((`SPIMSP_RATE_DIV16 / 2) - 1)
`define SPIMSP_HALF_DIV64 6'((`SPIMSP_RATE_DIV64 / 2) - 1)

`define SPIMSP_BITS_PER_BYTE 4'h8
`define SPIMSP_LAST_BIT 4'h7
`define SPIMSP_LAST_EDGE 5'h0f

// Reset values
`define SPIMSP_RST_BYTE 8'h00
`define SPIMSP_RST_PINS 3'h4

`endif

// File: hdl/spimsp_pkg.sv
package spimsp_pkg;

    typedef enum logic [1:0] {
        SPIMSP_IDLE,
        SPIMSP_RUN,
        SPIMSP_TAIL
    } spimsp_state_e;

    typedef logic [7:0] spimsp_byte_t;

endpackage

// File: hdl/spimsp_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchroniser; output moves only once stages two and three agree
module spimsp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
        end else begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Per bit: a disagreement holds the previous level
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            level_o <= RESET_VAL;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    level_o[i] <= stage2[i];
                end
            end
        end
    end
endmodule

// File: hdl/spimsp_port.sv
`timescale 1ns/1ps
`include "spimsp_regs.svh"

// Function
// - Port acts only while enable bit set
// - One shift register, full duplex, MSB first
// - Full byte loads buffer, sets full, irq
// - Buffer write while busy dropped, collision set
// - Buffer read clears the full flag
// - Shift register reached only via buffer
// - Master starts shifting on buffer write
// - Master with output disabled keeps receiving
// - Idle clock level set by control bit
// - Master rate: div 4, 16, 64, timer/2
// - Edge select set: data valid before edge
// - Change on own edge, capture opposite
// - Master sample phase picks middle or end sampling
// - Slave shifts on external clock, flags done
// - Slave works asleep, byte wakes system
// - Select mode: active only with select low
// - Select high releases data output at once
// - Select high resets port logic
// - Port reset forces bit counter zero
// - Device reset disables port, aborts transfer
// - Master freezes while asleep, then resumes
module spimsp_port
    import spimsp_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic port_enable_i,
    input wire logic [3:0] mode_i,
    input wire logic clock_idle_level_i,
    input wire logic clock_edge_sel_i,
    input wire logic input_sample_phase_i,
    input wire logic serial_data_out_disable_i,
    input wire logic sleep_i,
    input wire logic timer2_tick_i,
    input wire logic buf_wr_i,
    input wire logic [7:0] buf_wdata_i,
    input wire logic buf_rd_i,
    input wire logic irq_clear_i,
    input wire logic collision_clear_i,
    input wire logic sck_i,
    input wire logic serial_data_in_i,
    input wire logic ss_n_i,
    output logic [7:0] serial_buffer_o,
    output logic buffer_full_flag_o,
    output logic transfer_irq_flag_o,
    output logic write_collision_flag_o,
    output logic wake_o,
    output logic sck_o,
    output logic sck_oe_o,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_o
);
    logic sck_f;
    logic sdi_f;
    logic ss_n_f;
    logic sck_prev;
    spimsp_state_e state;
    spimsp_byte_t shift_register;
    logic [3:0] bit_cnt;
    logic [4:0] edge_cnt;
    logic [5:0] pre_cnt;
    logic [5:0] half_max;
    logic pend;
    logic is_master;
    logic is_slave_ss;
    logic is_slave;
    logic port_rst;
    logic tick;
    logic lead_ev;
    logic trail_ev;
    logic sample_ev;
    logic shift_ev;
    logic do_sample;
    logic byte_done;
    logic busy;
    logic wr_ok;
    spimsp_byte_t next_shift;
    logic [2:0] samp_dly;
    logic bit_ev;
    spimsp_byte_t rx_byte;

    spimsp_sync #(
        .WIDTH(3),
        .RESET_VAL(`SPIMSP_RST_PINS)
    ) u_sync (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .pin_i({ss_n_i, sck_i, serial_data_in_i}),
        .level_o({ss_n_f, sck_f, sdi_f})
    );

    assign is_master = (mode_i[3:2] == 2'b00);
    assign is_slave_ss = (mode_i == `SPIMSP_MODE_SLV_SS);
    assign is_slave = is_slave_ss || (mode_i == `SPIMSP_MODE_SLV_FREE);
    assign port_rst = !port_enable_i || !(is_master || is_slave) || (is_slave_ss && ss_n_f);

    always_comb begin
        unique case (mode_i[1:0])
            2'b00: half_max = `SPIMSP_HALF_DIV4;
            2'b01: half_max = `SPIMSP_HALF_DIV16;
            2'b10: half_max = `SPIMSP_HALF_DIV64;
            2'b11: half_max = `SPIMSP_HALF_DIV4;
        endcase
    end

    // No ticks while asleep freezes the byte
    assign tick = is_master && !port_rst && (state != SPIMSP_IDLE) && !sleep_i &&
        ((mode_i == `SPIMSP_MODE_TMR2) ? timer2_tick_i : (pre_cnt == half_max));

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_cnt <= 6'h00;
        end else if (port_rst || state == SPIMSP_IDLE || tick) begin
            pre_cnt <= 6'h00;
        end else if (!sleep_i) begin
            pre_cnt <= pre_cnt + 6'h01;
        end
    end

    // Leading edge leaves the idle level, trailing edge returns to it
    always_comb begin
        if (is_master) begin
            lead_ev = tick && (state == SPIMSP_RUN) && !edge_cnt[0];
            trail_ev = tick && (state == SPIMSP_RUN) && edge_cnt[0];
        end else begin
            // Slave edges from the external clock
            lead_ev = !port_rst && (sck_f != sck_prev) && (sck_f != clock_idle_level_i);
            trail_ev = !port_rst && (sck_f != sck_prev) && (sck_f == clock_idle_level_i);
        end
    end

    // Capture opposite to the output edge
    assign sample_ev = clock_edge_sel_i ? lead_ev : trail_ev;
    assign shift_ev = clock_edge_sel_i ? trail_ev : lead_ev;
    // End-of-output sampling slips half a period
    assign do_sample = (sample_ev && !(is_master && input_sample_phase_i)) || (pend && tick);
    // Master capture lags its strobe: the data pin crosses the synchroniser
    assign bit_ev = is_master ? samp_dly[2] : do_sample;
    assign byte_done = bit_ev && (bit_cnt == `SPIMSP_LAST_BIT);
    // MSB first, in and out together
    assign next_shift = {shift_register[6:0], sdi_f};
    assign rx_byte = is_master ? {shift_register[7:1], sdi_f} : next_shift;
    assign busy = (state != SPIMSP_IDLE) || (bit_cnt != 4'h0);
    assign wr_ok = buf_wr_i && !busy;

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= sck_f;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= SPIMSP_IDLE;
            edge_cnt <= 5'h00;
        end else if (port_rst || !is_master) begin
            state <= SPIMSP_IDLE;
            edge_cnt <= 5'h00;
        end else begin
            unique case (state)
                SPIMSP_IDLE: begin
                    edge_cnt <= 5'h00;
                    if (wr_ok) begin
                        state <= SPIMSP_RUN;
                    end
                end
                SPIMSP_RUN: begin
                    if (tick) begin
                        edge_cnt <= edge_cnt + 5'h01;
                        if (edge_cnt == `SPIMSP_LAST_EDGE) begin
                            edge_cnt <= 5'h00;
                            if (input_sample_phase_i) begin
                                state <= SPIMSP_TAIL;
                            end else if (!serial_data_out_disable_i) begin
                                state <= SPIMSP_IDLE;
                            end
                        end
                    end
                end
                SPIMSP_TAIL: begin
                    if (tick) begin
                        // Receive-only line monitor runs on without writes
                        state <= serial_data_out_disable_i ? SPIMSP_RUN : SPIMSP_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pend <= 1'b0;
        end else if (port_rst) begin
            pend <= 1'b0;
        end else if (is_master && input_sample_phase_i && sample_ev) begin
            pend <= 1'b1;
        end else if (tick) begin
            pend <= 1'b0;
        end
    end

    // Three cycles matches the pin path; a strobe is at least four apart
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            samp_dly <= 3'h0;
        end else if (port_rst) begin
            samp_dly <= 3'h0;
        end else begin
            samp_dly <= {samp_dly[1:0], do_sample && is_master};
        end
    end

    // Loaded only through the buffer write
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift_register <= `SPIMSP_RST_BYTE;
        end else if (wr_ok) begin
            shift_register <= buf_wdata_i;
        end else if (do_sample) begin
            shift_register <= is_master ? {shift_register[6:0], 1'b0} : next_shift;
        end else if (bit_ev) begin
            shift_register[0] <= sdi_f;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bit_cnt <= 4'h0;
        end else if (port_rst) begin
            bit_cnt <= 4'h0;
        end else if (byte_done) begin
            bit_cnt <= 4'h0;
        end else if (bit_ev) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            serial_buffer_o <= `SPIMSP_RST_BYTE;
        end else if (byte_done) begin
            serial_buffer_o <= rx_byte;
        end
    end

    // Read clears full; new byte wins
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            buffer_full_flag_o <= 1'b0;
        end else if (byte_done) begin
            buffer_full_flag_o <= 1'b1;
        end else if (buf_rd_i) begin
            buffer_full_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            transfer_irq_flag_o <= 1'b0;
        end else if (byte_done) begin
            transfer_irq_flag_o <= 1'b1;
        end else if (irq_clear_i) begin
            transfer_irq_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            write_collision_flag_o <= 1'b0;
        end else if (buf_wr_i && busy) begin
            write_collision_flag_o <= 1'b1;
        end else if (collision_clear_i) begin
            write_collision_flag_o <= 1'b0;
        end
    end

    // Slave byte wakes the sleeping system
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= byte_done && sleep_i && is_slave;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_o <= 1'b0;
        end else if (state != SPIMSP_RUN) begin
            sck_o <= clock_idle_level_i;
        end else if (tick) begin
            sck_o <= !sck_o;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sck_oe_o <= 1'b0;
        end else begin
            sck_oe_o <= port_enable_i && is_master;
        end
    end

    // Output enable follows select at once
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            serial_data_out_oe_o <= 1'b0;
        end else begin
            serial_data_out_oe_o <= port_enable_i && !serial_data_out_disable_i &&
                (is_master || (is_slave && !port_rst));
        end
    end

    // MSB presented at load, before first edge
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            serial_data_out_o <= 1'b0;
        end else if (wr_ok) begin
            serial_data_out_o <= buf_wdata_i[7];
        end else if (shift_ev) begin
            serial_data_out_o <= do_sample ? shift_register[6] : shift_register[7];
        end else if (trail_ev && bit_cnt == 4'h0 && !is_master) begin
            // Slave re-presents next MSB between bytes
            serial_data_out_o <= shift_register[7];
        end
    end

    en_off_pins_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        !port_enable_i |=> !sck_oe_o && !serial_data_out_oe_o)
        else $error("pins driven while port disabled");

    buf_load_flags_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        byte_done |=> buffer_full_flag_o && transfer_irq_flag_o
            && serial_buffer_o == $past(rx_byte))
        else $error("byte done without buffer load and flags");

    wr_collision_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        buf_wr_i && busy |=> write_collision_flag_o && !(state == SPIMSP_RUN && $past(state) == SPIMSP_IDLE))
        else $error("collision not flagged");

    read_clear_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        buf_rd_i && !byte_done |=> !buffer_full_flag_o)
        else $error("read did not clear buffer full");

    master_start_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        wr_ok && is_master && !port_rst |=> state == SPIMSP_RUN)
        else $error("master did not start on write");

    idle_level_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        state == SPIMSP_IDLE ##1 state == SPIMSP_IDLE |-> sck_o == $past(clock_idle_level_i))
        else $error("serial clock not at idle level");

    // Fastest rate toggles every two clocks
    div4_rate_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        tick && mode_i == `SPIMSP_MODE_DIV4 ##1 (state == SPIMSP_RUN && !sleep_i
            && mode_i == `SPIMSP_MODE_DIV4 && !port_rst) |-> !tick ##1 tick)
        else $error("divide by four rate wrong");

    msb_early_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        wr_ok |=> serial_data_out_o == $past(buf_wdata_i[7]) && sck_o == $past(sck_o))
        else $error("MSB not presented before first edge");

    ss_release_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        is_slave_ss && ss_n_f |=> !serial_data_out_oe_o)
        else $error("output still driven with select high");

    cnt_reset_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        port_rst |=> bit_cnt == 4'h0)
        else $error("bit counter not cleared");

    sleep_hold_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        sleep_i && state == SPIMSP_RUN && !port_rst ##1 !port_rst && is_master
            |-> $stable(sck_o) && $stable(edge_cnt))
        else $error("master moved while asleep");

    slave_wake_a: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        byte_done && sleep_i && is_slave |=> wake_o)
        else $error("no wake on slave byte");

    master_byte_c: cover property (@(posedge clock_i) disable iff (!arst_n_i)
        byte_done && is_master);
    slave_byte_c: cover property (@(posedge clock_i) disable iff (!arst_n_i)
        byte_done && is_slave_ss);
    collision_c: cover property (@(posedge clock_i) disable iff (!arst_n_i)
        buf_wr_i && busy);
    ss_abort_c: cover property (@(posedge clock_i) disable iff (!arst_n_i)
        is_slave_ss && ss_n_f && bit_cnt != 4'h0);
endmodule

// File: bench/spimsp_partner.sv
`timescale 1ns/1ps
module spimsp_partner (
    input wire logic idle_lvl_i,
    input wire logic edge_sel_i,
    input wire logic sck_i,
    input wire logic sdo_i,
    output logic sck_o,
    output logic ss_n_o,
    output logic sdi_o
);
    logic master_role = 1'b0;
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    initial begin
        sck_o = 1'b0;
        ss_n_o = 1'b1;
        sdi_o = 1'b1;
    end
    task automatic load(input logic [7:0] b);
        tx = b;
        sdi_o = b[7];
    endtask
    always @(sck_i) begin
        if (!master_role) begin
            if (sck_i !== idle_lvl_i) begin
                if (edge_sel_i) begin
                    rx = {rx[6:0], sdo_i};
                end else begin
                    sdi_o = tx[7];
                end
            end else begin
                if (!edge_sel_i) begin
                    rx = {rx[6:0], sdo_i};
                end
                tx = {tx[6:0], 1'b0};
                if (edge_sel_i) begin
                    sdi_o = tx[7];
                end
            end
        end
    end
    task automatic xfer(input logic [7:0] b, input int hp, input int nbits,
                        output logic [7:0] got);
        got = 8'h00;
        master_role = 1'b1;
        #3;
        load(b);
        ss_n_o = 1'b0;
        #(hp * 10);
        repeat (nbits) begin
            sck_o = ~idle_lvl_i;
            got = {got[6:0], sdo_i};
            #(hp * 10);
            sck_o = idle_lvl_i;
            tx = {tx[6:0], 1'b0};
            sdi_o = tx[7];
            #(hp * 10);
        end
        // Released line: no pull, so show the inverse
        ss_n_o = 1'b1;
        sdi_o = ~sdi_o;
        master_role = 1'b0;
    endtask
endmodule

// File: bench/test_spi_master_slave_port.sv
`timescale 1ns/1ps
module test_spi_master_slave_port;
    import spimsp_pkg::*;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic port_enable_i = 1'b0;
    logic [3:0] mode_i = 4'h0;
    logic idle_lvl = 1'b0;
    logic phase = 1'b0;
    logic edge_sel = 1'b1;
    logic sdo_off = 1'b0;
    logic sleep_i = 1'b0;
    logic tmr_tick = 1'b0;
    logic buf_wr_i = 1'b0;
    spimsp_byte_t buf_wdata_i = 8'h00;
    logic buf_rd_i = 1'b0;
    logic clr = 1'b0;
    logic sck_pin, ss_n_pin, sdi_pin, full, irq, coll, wake_o;
    logic sck_o, sck_oe_o, serial_data_out, sdo_oe;
    spimsp_byte_t rx_buf;
    spimsp_byte_t got;
    logic woke = 1'b0;
    logic [1:0] tcnt = 2'h0;
    int fails = 0;
    int compares = 0;
    int gap;
    int halfs[4] = '{2, 8, 32, 3};

    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
        tmr_tick <= (tcnt == 2'h2);
        if (wake_o === 1'b1 && sleep_i) begin
            woke <= 1'b1;
        end
    end

    spimsp_port u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .port_enable_i(port_enable_i),
        .mode_i(mode_i), .clock_idle_level_i(idle_lvl), .clock_edge_sel_i(edge_sel),
        .input_sample_phase_i(phase), .serial_data_out_disable_i(sdo_off),
        .sleep_i(sleep_i), .timer2_tick_i(tmr_tick), .buf_wr_i(buf_wr_i),
        .buf_wdata_i(buf_wdata_i), .buf_rd_i(buf_rd_i), .irq_clear_i(clr),
        .collision_clear_i(clr), .sck_i(sck_pin), .serial_data_in_i(sdi_pin),
        .ss_n_i(ss_n_pin), .serial_buffer_o(rx_buf), .buffer_full_flag_o(full),
        .transfer_irq_flag_o(irq), .write_collision_flag_o(coll), .wake_o(wake_o),
        .sck_o(sck_o), .sck_oe_o(sck_oe_o), .serial_data_out_o(serial_data_out),
        .serial_data_out_oe_o(sdo_oe));
    spimsp_partner u_peer (.idle_lvl_i(idle_lvl), .edge_sel_i(edge_sel), .sck_i(sck_o), .sdo_i(serial_data_out),
        .sck_o(sck_pin), .ss_n_o(ss_n_pin), .sdi_o(sdi_pin));

    task automatic tick();
        @(posedge clock_i);
        #1;
    endtask
    task automatic chk8(input string what, input spimsp_byte_t exp, input spimsp_byte_t seen);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic seen);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic wr(input spimsp_byte_t b);
        @(posedge clock_i);
        buf_wr_i <= 1'b1;
        buf_wdata_i <= b;
        @(posedge clock_i);
        buf_wr_i <= 1'b0;
    endtask
    // Read then clear both flags, as software would
    task automatic rd_clr();
        @(posedge clock_i);
        buf_rd_i <= 1'b1;
        @(posedge clock_i);
        buf_rd_i <= 1'b0;
        clr <= 1'b1;
        @(posedge clock_i);
        clr <= 1'b0;
        tick();
    endtask
    task automatic wait_full();
        for (int n = 0; n < 3000 && full !== 1'b1; n++) begin
            tick();
        end
        chk1("full flag", 1'b1, full);
    endtask
    task automatic edge_gap(input int lim, output int n);
        logic s;
        s = sck_o;
        n = 0;
        do begin
            tick();
            n++;
        end while (sck_o === s && n < lim);
    endtask
    task automatic cfg(input logic [3:0] m, input logic idle, input logic ph, input logic ce);
        @(posedge clock_i);
        port_enable_i <= 1'b0;
        @(posedge clock_i);
        mode_i <= m;
        edge_sel <= ce;
        idle_lvl <= idle;
        phase <= ph;
        @(posedge clock_i);
        port_enable_i <= 1'b1;
        repeat (3) tick();
    endtask
    task automatic give_verdict();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #(40000 * 10);
        fails++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge clock_i);
        arst_n_i <= 1'b1;
        tick();
        chk1("full after reset", 1'b0, full);
        chk1("clock drive after reset", 1'b0, sck_oe_o);
        for (int m = 0; m < 4; m++) begin
            cfg(4'(m), m[0], m == 1, m != 2);
            chk1("idle clock", m[0], sck_o);
            u_peer.load(8'h3c + 8'(m));
            wr(8'ha5 ^ 8'(m));
            edge_gap(300, gap);
            edge_gap(300, gap);
            chk8("half period", 8'(halfs[m]), 8'(gap));
            wr(8'h11);
            wait_full();
            chk8("received byte", 8'h3c + 8'(m), rx_buf);
            chk8("sent byte", 8'ha5 ^ 8'(m), u_peer.rx);
            chk1("done flag", 1'b1, irq);
            chk1("collision flag", 1'b1, coll);
            rd_clr();
            chk1("full after read", 1'b0, full);
            chk1("collision cleared", 1'b0, coll);
        end
        wr(8'hff);
        repeat (6) tick();
        @(posedge clock_i);
        port_enable_i <= 1'b0;
        repeat (3) tick();
        chk1("clock drive while off", 1'b0, sck_oe_o);
        edge_gap(20, gap);
        chk8("clock still while off", 8'd20, 8'(gap));
        chk1("no byte while off", 1'b0, full);
        @(posedge clock_i);
        port_enable_i <= 1'b1;
        repeat (3) tick();
        u_peer.load(8'h69);
        wr(8'h96);
        repeat (5) tick();
        @(posedge clock_i);
        sleep_i <= 1'b1;
        tick();
        edge_gap(20, gap);
        chk8("clock frozen asleep", 8'd20, 8'(gap));
        @(posedge clock_i);
        sleep_i <= 1'b0;
        wait_full();
        chk8("byte after wake", 8'h69, rx_buf);
        chk8("sent after wake", 8'h96, u_peer.rx);
        rd_clr();
        @(posedge clock_i);
        sdo_off <= 1'b1;
        u_peer.load(8'h81);
        wr(8'h00);
        wait_full();
        chk1("data drive disabled", 1'b0, sdo_oe);
        chk8("monitor byte", 8'h81, rx_buf);
        rd_clr();
        wait_full();
        chk8("monitor repeat", 8'h00, rx_buf);
        @(posedge clock_i);
        sdo_off <= 1'b0;
        sleep_i <= 1'b1;
        cfg(4'h4, 1'b0, 1'b0, 1'b1);
        rd_clr();
        wr(8'hc3);
        u_peer.xfer(8'h96, 8, 8, got);
        chk8("slave sent", 8'hc3, got);
        wait_full();
        chk8("slave received", 8'h96, rx_buf);
        chk1("slave done flag", 1'b1, irq);
        chk1("wake seen", 1'b1, woke);
        rd_clr();
        wr(8'h5e);
        u_peer.xfer(8'hf0, 8, 3, got);
        repeat (8) tick();
        chk1("data released", 1'b0, sdo_oe);
        chk1("no partial byte", 1'b0, full);
        u_peer.xfer(8'h0f, 8, 8, got);
        wait_full();
        chk8("byte after select reset", 8'h0f, rx_buf);
        give_verdict();
    end
endmodule
